// ===== design/csg_glue.sv
`timescale 1ns/10ps
module csg_glue #(
    parameter logic [15:0] BASE_ADDR = csg_pkg::PORT_BASE,
    parameter logic [7:0]  REC_CYC   = csg_pkg::RECOVERY_CYC
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [15:0] cpu_ad_in,
    output logic      [15:0] cpu_ad_out,
    output logic             cpu_ad_oe,
    input  wire logic        cpu_ale,
    input  wire logic        cpu_rd_n,
    input  wire logic        cpu_wr_n,
    input  wire logic        cpu_io_sel,
    input  wire logic        max_mode,
    input  wire logic        io_read_command_n,
    input  wire logic        io_write_command_n,
    input  wire logic        cpu_irq_ack_pulse_n,
    input  wire logic        fast_mode,
    output logic             cpu_ready,
    input  wire logic        init_start,
    output logic             init_busy,
    output logic             init_done,
    output logic             ctrl_cs_n,
    output logic             ctrl_rd_n,
    output logic             ctrl_wr_n,
    output logic             ctrl_cd,
    output logic             ctrl_irq_ack_input_n,
    input  wire logic [7:0]  ctrl_d_in,
    output logic      [7:0]  ctrl_d_out,
    output logic             ctrl_d_oe
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        csg_pkg::csg_state_t st;
        logic [7:0]          cnt;
        logic [15:0]         addr;
        logic                armed;
        logic                src_init;
        logic                cd;
        logic                cs;
        logic                rd;
        logic                wr;
        logic                ack;
        logic [7:0]          dout;
        logic                doe;
        logic [7:0]          vec;
        logic                done;
    } csg_glue_st_t;

    csg_glue_st_t r_q;
    csg_glue_st_t r_d;

    logic       init_req;
    logic       init_we;
    logic       init_cd;
    logic [7:0] init_wdata;
    logic       init_ack;
    logic       io_rd;
    logic       io_wr;
    logic       hit;
    logic       ack_low;
    logic       strobe_now;

    // Wait limit for an access; the fast clock needs two more cycles.
    function automatic logic [7:0] wait_lim(input logic [7:0] base, input logic fast);
        wait_lim = fast ? base + csg_pkg::FAST_WAIT_CYC : base;
    endfunction

    // ------------------------------------------------------------------
    // Qualifiers
    // ------------------------------------------------------------------
    assign io_rd      = max_mode ? !io_read_command_n
                                 : (!cpu_rd_n && cpu_io_sel);
    assign io_wr      = max_mode ? !io_write_command_n
                                 : (!cpu_wr_n && cpu_io_sel);
    assign hit        = (r_q.addr[15:csg_pkg::DECODE_LSB] == BASE_ADDR[15:csg_pkg::DECODE_LSB]);
    assign ack_low    = !cpu_irq_ack_pulse_n;
    assign strobe_now = r_q.ack ? ack_low : (io_rd || io_wr);

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_comb begin
        r_d = r_q;
        if (cpu_ale) begin
            r_d.addr = cpu_ad_in;
        end
        case (r_q.st)
            csg_pkg::S_IDLE: begin
                r_d.cnt   = 8'h00;
                r_d.done  = 1'b0;
                r_d.armed = 1'b0;
                if (ack_low) begin
                    r_d.ack = 1'b1;
                    r_d.st  = csg_pkg::S_ACK;
                end else if (hit && io_rd) begin
                    r_d.src_init = 1'b0;
                    r_d.cd       = r_q.addr[csg_pkg::CD_BIT];
                    r_d.cs       = 1'b1;
                    r_d.rd       = 1'b1;
                    r_d.st       = csg_pkg::S_RD;
                end else if (hit && io_wr) begin
                    r_d.src_init = 1'b0;
                    r_d.cd       = r_q.addr[csg_pkg::CD_BIT];
                    r_d.cs       = 1'b1;
                    r_d.dout     = cpu_ad_in[7:0];
                    r_d.doe      = 1'b1;
                    r_d.st       = csg_pkg::S_WSET;
                end else if (init_req) begin
                    r_d.src_init = 1'b1;
                    r_d.cd       = init_cd;
                    r_d.cs       = 1'b1;
                    if (init_we) begin
                        r_d.dout = init_wdata;
                        r_d.doe  = 1'b1;
                        r_d.st   = csg_pkg::S_WSET;
                    end else begin
                        r_d.rd = 1'b1;
                        r_d.st = csg_pkg::S_RD;
                    end
                end
            end
            csg_pkg::S_ACK: begin
                if (r_q.cnt < csg_pkg::SETTLE_CYC) begin
                    r_d.cnt = r_q.cnt + 8'h01;
                end
                if (!ack_low) begin
                    r_d.armed = 1'b1;
                end
                if (r_q.armed && ack_low && r_q.cnt >= csg_pkg::SETTLE_CYC) begin
                    r_d.rd  = 1'b1;
                    r_d.cnt = 8'h00;
                    r_d.st  = csg_pkg::S_VEC;
                end
            end
            csg_pkg::S_VEC, csg_pkg::S_RD: begin
                r_d.cnt = r_q.cnt + 8'h01;
                if (r_q.cnt == wait_lim(csg_pkg::RD_BASE_CYC, fast_mode) - 8'h01) begin
                    r_d.vec  = ctrl_d_in;
                    r_d.done = 1'b1;
                    r_d.cnt  = 8'h00;
                    r_d.st   = csg_pkg::S_END;
                end
            end
            csg_pkg::S_WSET: begin
                r_d.cnt = r_q.cnt + 8'h01;
                if (r_q.cnt == csg_pkg::WR_SETUP_CYC - 8'h01) begin
                    r_d.wr  = 1'b1;
                    r_d.cnt = 8'h00;
                    r_d.st  = csg_pkg::S_WR;
                end
            end
            csg_pkg::S_WR: begin
                r_d.cnt = r_q.cnt + 8'h01;
                if (r_q.cnt == wait_lim(csg_pkg::WR_BASE_CYC, fast_mode) - 8'h01) begin
                    r_d.wr   = 1'b0;
                    r_d.done = 1'b1;
                    r_d.cnt  = 8'h00;
                    r_d.st   = csg_pkg::S_END;
                end
            end
            csg_pkg::S_END: begin
                if (r_q.src_init || !strobe_now) begin
                    r_d.cs  = 1'b0;
                    r_d.rd  = 1'b0;
                    r_d.ack = 1'b0;
                    r_d.doe = 1'b0;
                    r_d.cnt = 8'h00;
                    // Done drops here so a request arriving in recovery sees ready low.
                    r_d.done = 1'b0;
                    r_d.st  = csg_pkg::S_REC;
                end
            end
            default: begin
                r_d.cnt = r_q.cnt + 8'h01;
                if (r_q.cnt == REC_CYC - 8'h01) begin
                    r_d.done = 1'b0;
                    r_d.st   = csg_pkg::S_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Ready is the only means of stretching a cycle; a pending request keeps
    // it low until any access, not only its own, sets done; the first acknowledge runs free unless armed is still set.
    assign cpu_ready = !(((hit && (io_rd || io_wr)) || (ack_low && r_q.armed))
                         && !r_q.done);

    assign cpu_ad_out = {8'h00, r_q.vec};
    assign cpu_ad_oe  = (r_q.st == csg_pkg::S_END) && r_q.rd && !r_q.src_init
                        && strobe_now;

    assign init_ack = (r_q.st == csg_pkg::S_REC) && r_q.src_init
                      && (r_q.cnt == REC_CYC - 8'h01);

    assign ctrl_cs_n            = !r_q.cs;
    assign ctrl_rd_n            = !r_q.rd;
    assign ctrl_wr_n            = !r_q.wr;
    assign ctrl_cd              = r_q.cd;
    assign ctrl_irq_ack_input_n = !r_q.ack;
    assign ctrl_d_out           = r_q.dout;
    assign ctrl_d_oe            = r_q.doe;

    // ------------------------------------------------------------------
    // Initialization sequencer
    // ------------------------------------------------------------------
    csg_init_seq u_init (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .init_start (init_start),
        .init_ack   (init_ack),
        .init_req   (init_req),
        .init_we    (init_we),
        .init_cd    (init_cd),
        .init_wdata (init_wdata),
        .init_busy  (init_busy),
        .init_done  (init_done)
    );

endmodule

// ===== design/csg_init_seq.sv
`timescale 1ns/10ps
module csg_init_seq (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        init_start,
    input  wire logic        init_ack,
    output logic             init_req,
    output logic             init_we,
    output logic             init_cd,
    output logic [7:0]       init_wdata,
    output logic             init_busy,
    output logic             init_done
);

    typedef struct packed {
        csg_pkg::csg_init_state_t st;
        logic [3:0]               idx;
        logic [7:0]               wdata;
    } csg_init_st_t;

    csg_init_st_t r_q;
    csg_init_st_t r_d;

    always_comb begin
        r_d = r_q;
        case (r_q.st)
            csg_pkg::I_IDLE, csg_pkg::I_DONE: begin
                if (init_start) begin
                    r_d.st = csg_pkg::I_RD;
                end
            end
            csg_pkg::I_RD: begin
                if (init_ack) begin
                    r_d.st    = csg_pkg::I_WR;
                    r_d.idx   = 4'h0;
                    r_d.wdata = csg_pkg::INIT_TAB[0];
                end
            end
            default: begin
                if (init_ack) begin
                    if (r_q.idx == 4'(csg_pkg::INIT_LEN - 1)) begin
                        r_d.st = csg_pkg::I_DONE;
                    end else begin
                        r_d.idx   = r_q.idx + 4'h1;
                        r_d.wdata = csg_pkg::INIT_TAB[r_q.idx + 4'h1];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            r_q <= '{st: csg_pkg::I_IDLE, idx: 4'h0, wdata: 8'h00};
        end else begin
            r_q <= r_d;
        end
    end

    // A dummy status read first puts the pointer logic in a known state.
    assign init_req   = (r_q.st == csg_pkg::I_RD) || (r_q.st == csg_pkg::I_WR);
    assign init_we    = (r_q.st == csg_pkg::I_WR);
    assign init_cd    = 1'b1;
    assign init_wdata = r_q.wdata;
    assign init_busy  = init_req;
    assign init_done  = (r_q.st == csg_pkg::I_DONE);

endmodule

// ===== design/csg_pkg.sv
package csg_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int           CLK_NS          = 20;
    localparam int           SETTLE_NS       = 800;
    localparam int           SETTLE_CYC_INT  = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0]   SETTLE_CYC      = SETTLE_CYC_INT[7:0];
    localparam logic [7:0]   FAST_WAIT_CYC   = 8'h02;
    localparam logic [7:0]   RD_BASE_CYC     = 8'h04;
    localparam logic [7:0]   WR_SETUP_CYC    = 8'h01;
    localparam logic [7:0]   WR_BASE_CYC     = 8'h05;
    localparam logic [7:0]   RECOVERY_CYC    = 8'h0C;

    // ------------------------------------------------------------------
    // Port map
    // ------------------------------------------------------------------
    localparam logic [15:0]  PORT_BASE       = 16'hF900;
    localparam int           CD_BIT          = 1;
    localparam int           DECODE_LSB      = 2;

    // ------------------------------------------------------------------
    // Initialization table: register number, then value, in pairs
    // ------------------------------------------------------------------
    localparam int           INIT_LEN        = 16;
    localparam logic [7:0]   INIT_TAB [INIT_LEN] = '{
        8'h09, 8'hC0, 8'h03, 8'h41, 8'h04, 8'h4C, 8'h05, 8'h28,
        8'h0B, 8'h56, 8'h0C, 8'h0C, 8'h0D, 8'h00, 8'h0E, 8'h07
    };

    // ------------------------------------------------------------------
    // State types
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        S_IDLE, S_ACK, S_VEC, S_RD, S_WSET, S_WR, S_END, S_REC
    } csg_state_t;

    typedef enum logic [1:0] {
        I_IDLE, I_RD, I_WR, I_DONE
    } csg_init_state_t;

endpackage

// ===== dv/csg_dev_model.sv
`timescale 1ns/10ps
module csg_dev_model #(
    parameter logic [7:0] VEC    = 8'hA7,
    parameter logic [7:0] STATUS = 8'h3C
) (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       ctrl_cs_n,
    input  wire logic       ctrl_rd_n,
    input  wire logic       ctrl_wr_n,
    input  wire logic       ctrl_cd,
    input  wire logic       ctrl_irq_ack_input_n,
    input  wire logic [7:0] ctrl_d_out,
    output logic      [7:0] ctrl_d_in
);
    // ----------
    // Port model
    // ----------
    // Released data lines show the inverse of the last byte, never a stale copy.
    logic [7:0] reg_q [16];
    logic [7:0] data_q, last_q, last_reg_q;
    logic       ptr_q, wr_q, rd_first_q, any_wr_q;
    wire        vec_rd = !ctrl_irq_ack_input_n && !ctrl_rd_n;
    wire        sel_rd = !ctrl_cs_n && !ctrl_rd_n;
    // The daisy chain is taken as settled by the time the glue reads the vector.
    assign ctrl_d_in = vec_rd ? VEC : (sel_rd ? (ctrl_cd ? STATUS : data_q) : ~last_q);
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 16; i++) reg_q[i] <= 8'h00;
            {data_q, last_q, last_reg_q} <= 24'h000000;
            {ptr_q, wr_q, rd_first_q, any_wr_q} <= 4'h4;
        end else begin
            wr_q <= ctrl_wr_n;
            if (vec_rd || sel_rd) last_q <= ctrl_d_in;
            if (sel_rd && ctrl_cd) begin
                ptr_q <= 1'b0;
                if (!any_wr_q) rd_first_q <= 1'b1;
            end
            if (!wr_q && ctrl_wr_n && !ctrl_cs_n) begin
                any_wr_q <= 1'b1;
                if (!ctrl_cd) data_q <= ctrl_d_out;
                else if (!ptr_q) {last_reg_q, ptr_q} <= {ctrl_d_out, 1'b1};
                else {reg_q[last_reg_q[3:0]], ptr_q} <= {ctrl_d_out, 1'b0};
            end
        end
    end
endmodule

// ===== dv/csg_props.sv
`timescale 1ns/10ps
module csg_props #(
    parameter logic [7:0] REC_CYC = csg_pkg::RECOVERY_CYC
) (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic [15:0] cpu_ad_in,
    input wire logic        cpu_ale,
    input wire logic        cpu_rd_n,
    input wire logic        cpu_wr_n,
    input wire logic        cpu_io_sel,
    input wire logic        max_mode,
    input wire logic        io_read_command_n,
    input wire logic        io_write_command_n,
    input wire logic        cpu_irq_ack_pulse_n,
    input wire logic        fast_mode,
    input wire logic        cpu_ready,
    input wire logic        ctrl_cs_n,
    input wire logic        ctrl_rd_n,
    input wire logic        ctrl_wr_n,
    input wire logic        ctrl_cd,
    input wire logic        ctrl_irq_ack_input_n,
    input wire logic [7:0]  ctrl_d_out,
    input wire logic        ctrl_d_oe
);
    // ----------
    // Helper logic
    // ----------
    // Counters saturate so a long idle stretch never wraps into a short gap.
    logic [15:0] addr_q;
    logic [7:0]  gap_q;
    logic [7:0]  ack_q;
    wire         req = !cpu_rd_n || !cpu_wr_n || !io_read_command_n || !io_write_command_n;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            addr_q <= 16'h0000;
            gap_q <= 8'hFF;
            ack_q <= 8'h00;
        end else begin
            if (cpu_ale) begin
                addr_q <= cpu_ad_in;
            end
            gap_q <= ctrl_cs_n ? ((gap_q == 8'hFF) ? gap_q : gap_q + 8'h01) : 8'h00;
            ack_q <= ctrl_irq_ack_input_n ? 8'h00 : ((ack_q == 8'hFF) ? ack_q : ack_q + 8'h01);
        end
    end
    // ----------
    // Properties
    // ----------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    sequence rd_slow;
        !cpu_ready[*3] ##[1:3] cpu_ready;
    endsequence
    sequence rd_fast;
        !cpu_ready[*5] ##[1:3] cpu_ready;
    endsequence
    sequence wr_slow;
        !ctrl_wr_n[*5] ##[1:2] ctrl_wr_n;
    endsequence
    sequence wr_fast;
        !ctrl_wr_n[*7] ##[1:2] ctrl_wr_n;
    endsequence
    chk_ack_from_pulse: assert property (
        $fell(ctrl_irq_ack_input_n) |-> !$past(cpu_irq_ack_pulse_n)) else $error("ack without pulse");
    chk_settle_time: assert property (
        $fell(ctrl_rd_n) && !ctrl_irq_ack_input_n |-> ack_q >= csg_pkg::SETTLE_CYC)
        else $error("vector read before settle time");
    chk_vec_strobe: assert property (
        $fell(ctrl_rd_n) && !ctrl_irq_ack_input_n |-> !$past(cpu_irq_ack_pulse_n))
        else $error("vector read without second pulse");
    chk_rd_wait_slow: assert property (
        $fell(ctrl_rd_n) && (req || !cpu_irq_ack_pulse_n) && !fast_mode |-> rd_slow)
        else $error("read wait length wrong");
    chk_rd_wait_fast: assert property (
        $fell(ctrl_rd_n) && (req || !cpu_irq_ack_pulse_n) && fast_mode |-> rd_fast)
        else $error("fast read wait length wrong");
    chk_wr_setup: assert property (
        $fell(ctrl_wr_n) |-> $past(ctrl_d_oe) && !$past(ctrl_cs_n) && $stable(ctrl_d_out))
        else $error("write strobe before data valid");
    chk_wr_width_slow: assert property (
        $fell(ctrl_wr_n) && !fast_mode |-> wr_slow) else $error("write strobe width wrong");
    chk_wr_width_fast: assert property (
        $fell(ctrl_wr_n) && fast_mode |-> wr_fast) else $error("fast write width wrong");
    chk_recovery_gap: assert property (
        $fell(ctrl_cs_n) |-> gap_q >= REC_CYC) else $error("recovery gap too short");
    chk_cd_latch: assert property (
        $fell(ctrl_cs_n) && req |-> ctrl_cd == addr_q[csg_pkg::CD_BIT])
        else $error("select bit not from latched address");
    chk_qual_mode: assert property (
        $fell(ctrl_cs_n) && req |-> (max_mode ? (!io_read_command_n || !io_write_command_n)
        : (cpu_io_sel && (!cpu_rd_n || !cpu_wr_n)))) else $error("access without qualifier");
    chk_data_pass: assert property (
        !ctrl_wr_n && req |-> ctrl_d_out == cpu_ad_in[7:0]) else $error("write data altered");
endmodule
bind csg_glue csg_props #(.REC_CYC(REC_CYC)) u_csg_props (.*);

// ===== dv/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    // ----------
    // Signals
    // ----------
    localparam logic [7:0] VEC  = 8'hA7;
    localparam logic [7:0] STAT = 8'h3C;
    logic        ref_clk = 1'b0, rst = 1'b1, cpu_ale = 1'b0, cpu_io_sel = 1'b0;
    logic        cpu_rd_n = 1'b1, cpu_wr_n = 1'b1, max_mode = 1'b0, fast_mode = 1'b0;
    logic        io_read_command_n = 1'b1, io_write_command_n = 1'b1, init_start = 1'b0;
    logic        cpu_irq_ack_pulse_n = 1'b1;
    logic [15:0] cpu_ad_in = 16'h0000, cpu_ad_out, r;
    logic [7:0]  ctrl_d_in, ctrl_d_out, b;
    logic        cpu_ad_oe, cpu_ready, init_busy, init_done, ctrl_cs_n, ctrl_rd_n, ctrl_wr_n;
    logic        ctrl_cd, ctrl_irq_ack_input_n, ctrl_d_oe;
    int          failures = 0, tests_run = 0;
    always #10 ref_clk = ~ref_clk;
    csg_glue u_csg_glue (.*);
    csg_dev_model #(.VEC(VEC), .STATUS(STAT)) u_csg_dev_model (.*);
    // ----------
    // Tasks
    // ----------
    function automatic logic [7:0] exp_reg(input logic [3:0] idx);
        logic [7:0] v;
        v = 8'h00;
        for (int i = 0; i < csg_pkg::INIT_LEN; i += 2) begin
            if (csg_pkg::INIT_TAB[i][3:0] == idx) v = csg_pkg::INIT_TAB[i + 1];
        end
        return v;
    endfunction
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic final_report();
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (cpu_ready !== 1'b1 && n < 300);
        if (cpu_ready !== 1'b1) begin
            check("cpu_ready", 16'h0001, {15'h0000, cpu_ready});
            final_report();
        end
    endtask
    task automatic io_acc(input logic wr, input logic [15:0] a, input logic [7:0] d,
                          output logic [15:0] q);
        @(posedge ref_clk);
        #1 cpu_ad_in = a;
        cpu_ale = 1'b1;
        cpu_io_sel = 1'b1;
        @(posedge ref_clk);
        #1 cpu_ale = 1'b0;
        cpu_ad_in = {8'h00, d};
        if (max_mode) {io_read_command_n, io_write_command_n} = {wr, !wr};
        else {cpu_rd_n, cpu_wr_n} = {wr, !wr};
        wait_ready();
        q = (cpu_ad_oe === 1'b1) ? cpu_ad_out : 16'hEEEE;
        #1 {cpu_rd_n, cpu_wr_n, io_read_command_n, io_write_command_n} = 4'hF;
        cpu_io_sel = 1'b0;
    endtask
    // Two pulses with a short gap; the glue must stretch the second one itself.
    // The first pulse is not stretched after a port access, so the bench leaves the recovery gap first.
    task automatic iack(input logic [7:0] exp);
        repeat (int'(csg_pkg::RECOVERY_CYC) + 2) @(posedge ref_clk);
        #1 cpu_irq_ack_pulse_n = 1'b0;
        repeat (2) @(posedge ref_clk);
        check("ack_input", 16'h0000, {15'h0000, ctrl_irq_ack_input_n});
        #1 cpu_irq_ack_pulse_n = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1 cpu_irq_ack_pulse_n = 1'b0;
        wait_ready();
        check("vector", {8'h00, exp}, (cpu_ad_oe === 1'b1) ? cpu_ad_out : 16'hEEEE);
        #1 cpu_irq_ack_pulse_n = 1'b1;
    endtask
    // ----------
    // Sequence
    // ----------
    initial begin
        void'($urandom(32'h025A));
        repeat (10) @(posedge ref_clk);
        #1 rst = 1'b0;
        @(posedge ref_clk);
        #1 init_start = 1'b1;
        @(posedge ref_clk);
        #1 init_start = 1'b0;
        check("init_busy", 16'h0001, {15'h0000, init_busy});
        for (int n = 0; n < 4000 && init_done !== 1'b1; n++) @(posedge ref_clk);
        check("init_done", 16'h0001, {15'h0000, init_done});
        if (init_done !== 1'b1) final_report();
        check("init_idle", 16'h0000, {15'h0000, init_busy});
        check("first_read", 16'h0001, {15'h0000, u_csg_dev_model.rd_first_q});
        for (int i = 0; i < 16; i++) begin
            b = u_csg_dev_model.reg_q[i];
            check("init_reg", {8'h00, exp_reg(i[3:0])}, {8'h00, b});
        end
        check("last_reg", 16'h000E, {8'h00, u_csg_dev_model.last_reg_q});
        for (int m = 0; m < 8; m++) begin
            @(posedge ref_clk);
            #1 {fast_mode, max_mode} = m[1:0];
            b = (m == 3) ? 8'h00 : ((m == 6) ? 8'hFF : 8'($urandom));
            io_acc(1'b1, csg_pkg::PORT_BASE, b, r);
            io_acc(1'b1, csg_pkg::PORT_BASE ^ 16'h0100, ~b, r);
            io_acc(1'b0, csg_pkg::PORT_BASE, 8'h00, r);
            check("data_port", {8'h00, b}, r);
            io_acc(1'b0, csg_pkg::PORT_BASE | 16'h0002, 8'h00, r);
            check("status_port", {8'h00, STAT}, r);
            iack(VEC);
        end
        final_report();
    end
endmodule
